// ==== rtl/iox_top.sv ====
// Functional notes
// - Input pin change asserts the alert output
// - Alert releases on return or input read
// - Output-configured pins never raise the alert
// - Alert clearing is tracked per 8-bit port
// - Output-to-input switch may cause false alert
// - Idle bus: nobody pulls either line low
// - Data stable while clock high; else control
// - Data falling with clock high is START
// - Data rising with clock high is STOP
// - Any number of bytes per transfer
// - Eight data bits plus one acknowledge bit
// - Transmitter releases data during acknowledge slot
// - Device acknowledges its own address and every byte written after it
// - Acknowledge held low over whole clock high
// - No acknowledge: device releases data line
// - Config one means input, zero means output
// - Further read bytes alternate within the pair
`timescale 1ns/10ps
`default_nettype none
module iox_top (
   // System clock, reset and enable
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // Link clock that oversamples the serial bus
   input  wire logic              link_clk,
   // Serial bus
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_n,
   // Address straps
   input  wire logic [2:0]        addr_pins,
   // Port pins
   input  wire iox_pkg::iox_pair_t io_in,
   output iox_pkg::iox_pair_t     io_out,
   output iox_pkg::iox_pair_t     io_oe_n,
   // Open-drain change alert
   output logic                   int_o,
   output logic                   int_oe_n
);
   import iox_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Link-domain declarations
   logic       lrst_meta_ff;
   logic       link_rst_ff;
   logic       len_meta_ff;
   logic       len_ff;
   iox_line_t  line_meta_ff;
   iox_line_t  line_ff;
   iox_line_t  line_prev_ff;
   iox_pair_t  io_lmeta_ff;
   iox_pair_t  io_link_ff;
   logic [2:0] addr_meta_ff;
   logic [2:0] addr_ff;
   iox_state_t state_ff;
   iox_state_t ret_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;
   logic [7:0] tx_ff;
   logic [2:0] ptr_ff;
   logic       mack_ok_ff;
   logic       sda_oe_n_ff;
   iox_pair_t  out_ff;
   iox_pair_t  pol_ff;
   iox_pair_t  cfg_ff;
   iox_pair_t  rd_raw_ff;
   logic [1:0] rd_tgl_ff;
   logic       cfg_tgl_ff;
   logic       scl_hi;
   logic       start_det;
   logic       stop_det;
   logic       scl_rise;
   logic       scl_fall;
   logic       byte_done;
   logic       wr_pulse;
   logic       tx_load;
   logic [7:0] rd_byte;

   // Pointer to the other register of the same pair
   function automatic logic [2:0] pair_next(input logic [2:0] p);
      return {p[2:1], ~p[0]};
   endfunction

   // Register read mux; input ports show pins through the inversion mask
   function automatic logic [7:0] reg_read(input logic [2:0] p, input iox_pair_t pins,
                                           input iox_pair_t o, input iox_pair_t n,
                                           input iox_pair_t c);
      logic [7:0] r;
      r = 8'h00;
      unique case (p[2:1])
         PAIR_IN:  r = p[0] ? (pins.p1 ^ n.p1) : (pins.p0 ^ n.p0);
         PAIR_OUT: r = p[0] ? o.p1 : o.p0;
         PAIR_POL: r = p[0] ? n.p1 : n.p0;
         PAIR_CFG: r = p[0] ? c.p1 : c.p0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset and enable brought into the link domain; release is synchronous
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lrst_meta_ff <= 1'h1;
         link_rst_ff  <= 1'h1;
      end else begin
         lrst_meta_ff <= 1'h0;
         link_rst_ff  <= lrst_meta_ff;
      end
   end

   always_ff @(posedge link_clk or posedge link_rst_ff) begin
      if (link_rst_ff) begin
         len_meta_ff <= 1'h0;
         len_ff      <= 1'h0;
      end else begin
         len_meta_ff <= clk_en;
         len_ff      <= len_meta_ff;
      end
   end

   // Bus lines, pins and straps through two stages; one extra for edges
   always_ff @(posedge link_clk or posedge link_rst_ff) begin
      if (link_rst_ff) begin
         line_meta_ff <= '1;
         line_ff      <= '1;
         line_prev_ff <= '1;
         io_lmeta_ff  <= {PIN_RST, PIN_RST};
         io_link_ff   <= {PIN_RST, PIN_RST};
         addr_meta_ff <= 3'h0;
         addr_ff      <= 3'h0;
      end else if (len_ff) begin
         line_meta_ff <= {scl_i, sda_i};
         line_ff      <= line_meta_ff;
         line_prev_ff <= line_ff;
         io_lmeta_ff  <= io_in;
         io_link_ff   <= io_lmeta_ff;
         addr_meta_ff <= addr_pins;
         addr_ff      <= addr_meta_ff;
      end
   end

   // Bus conditions; a data edge under a high clock is control, not data
   assign scl_hi    = line_ff.scl & line_prev_ff.scl;
   assign start_det = len_ff & scl_hi & line_prev_ff.sda & ~line_ff.sda;
   assign stop_det  = len_ff & scl_hi & ~line_prev_ff.sda & line_ff.sda;
   assign scl_rise  = len_ff & line_ff.scl & ~line_prev_ff.scl;
   assign scl_fall  = len_ff & ~line_ff.scl & line_prev_ff.scl;
   assign byte_done = scl_fall & (cnt_ff == BITS_PER_BYTE);
   assign wr_pulse  = (state_ff == ST_WDAT) & byte_done;
   assign tx_load   = scl_fall & (((state_ff == ST_SACK) & (ret_ff == ST_TX)) |
                                  ((state_ff == ST_MACK) & mack_ok_ff));
   assign rd_byte   = reg_read(ptr_ff, io_link_ff, out_ff, pol_ff, cfg_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Serial engine: bits sampled on clock rise, data driven after clock fall
   always_ff @(posedge link_clk or posedge link_rst_ff) begin
      if (link_rst_ff) begin
         state_ff    <= ST_IDLE;
         ret_ff      <= ST_IDLE;
         cnt_ff      <= CNT_ZERO;
         sh_ff       <= 8'h00;
         tx_ff       <= 8'h00;
         ptr_ff      <= PTR_RST;
         mack_ok_ff  <= 1'h0;
         sda_oe_n_ff <= 1'h1;
      end else if (start_det) begin
         state_ff    <= ST_ADDR;
         cnt_ff      <= CNT_ZERO;
         sda_oe_n_ff <= 1'h1;
      end else if (stop_det) begin
         state_ff    <= ST_IDLE;
         sda_oe_n_ff <= 1'h1;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               sda_oe_n_ff <= 1'h1;
            end
            ST_ADDR, ST_CMD, ST_WDAT: begin
               if (scl_rise) begin
                  sh_ff  <= {sh_ff[6:0], line_ff.sda};
                  cnt_ff <= 4'(cnt_ff + CNT_ONE);
               end else if (byte_done) begin
                  cnt_ff      <= CNT_ZERO;
                  sda_oe_n_ff <= 1'h0;
                  state_ff    <= ST_SACK;
                  if (state_ff == ST_ADDR) begin
                     if (sh_ff[7:1] == {ADDR_BASE, addr_ff}) begin
                        ret_ff <= sh_ff[0] ? ST_TX : ST_CMD;
                     end else begin
                        state_ff    <= ST_IDLE;
                        sda_oe_n_ff <= 1'h1;
                     end
                  end else if (state_ff == ST_CMD) begin
                     ptr_ff <= sh_ff[2:0];
                     ret_ff <= ST_WDAT;
                  end else begin
                     ptr_ff <= pair_next(ptr_ff);
                     ret_ff <= ST_WDAT;
                  end
               end
            end
            ST_SACK: begin
               if (scl_fall) begin
                  state_ff <= ret_ff;
                  if (ret_ff == ST_TX) begin
                     tx_ff       <= rd_byte;
                     sda_oe_n_ff <= rd_byte[7];
                     ptr_ff      <= pair_next(ptr_ff);
                  end else begin
                     sda_oe_n_ff <= 1'h1;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_ff <= 4'(cnt_ff + CNT_ONE);
               end else if (byte_done) begin
                  cnt_ff      <= CNT_ZERO;
                  sda_oe_n_ff <= 1'h1;
                  state_ff    <= ST_MACK;
               end else if (scl_fall) begin
                  sda_oe_n_ff <= tx_ff[6];
                  tx_ff       <= {tx_ff[6:0], 1'h0};
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  mack_ok_ff <= ~line_ff.sda;
                  if (line_ff.sda) begin
                     state_ff <= ST_IDLE;
                  end
               end else if (tx_load) begin
                  state_ff    <= ST_TX;
                  tx_ff       <= rd_byte;
                  sda_oe_n_ff <= rd_byte[7];
                  ptr_ff      <= pair_next(ptr_ff);
               end
            end
            default: begin
               state_ff    <= ST_IDLE;
               sda_oe_n_ff <= 1'h1;
            end
         endcase
      end
   end

   // Writable registers; input pair writes are dropped
   always_ff @(posedge link_clk or posedge link_rst_ff) begin
      if (link_rst_ff) begin
         out_ff     <= {OUT_RST, OUT_RST};
         pol_ff     <= {POL_RST, POL_RST};
         cfg_ff     <= {CFG_RST, CFG_RST};
         cfg_tgl_ff <= 1'h0;
      end else if (wr_pulse) begin
         unique case (ptr_ff[2:1])
            PAIR_IN:  ;
            PAIR_OUT: if (ptr_ff[0]) out_ff.p1 <= sh_ff; else out_ff.p0 <= sh_ff;
            PAIR_POL: if (ptr_ff[0]) pol_ff.p1 <= sh_ff; else pol_ff.p0 <= sh_ff;
            PAIR_CFG: begin
               if (ptr_ff[0]) cfg_ff.p1 <= sh_ff; else cfg_ff.p0 <= sh_ff;
               cfg_tgl_ff <= ~cfg_tgl_ff;
            end
         endcase
      end
   end

   // Raw pins captured at each input-port read, announced by a toggle
   always_ff @(posedge link_clk or posedge link_rst_ff) begin
      if (link_rst_ff) begin
         rd_raw_ff <= {PIN_RST, PIN_RST};
         rd_tgl_ff <= 2'h0;
      end else if (tx_load && (ptr_ff[2:1] == PAIR_IN)) begin
         if (ptr_ff[0]) begin
            rd_raw_ff.p1 <= io_link_ff.p1;
            rd_tgl_ff[1] <= ~rd_tgl_ff[1];
         end else begin
            rd_raw_ff.p0 <= io_link_ff.p0;
            rd_tgl_ff[0] <= ~rd_tgl_ff[0];
         end
      end
   end

   // Open-drain data, the output level is always low
   assign sda_o    = 1'h0;
   assign sda_oe_n = sda_oe_n_ff;
   assign io_out   = out_ff;
   assign io_oe_n  = cfg_ff;

   ////////////////////////////////////////////////////////////////////////////
   // System domain: alert detection
   iox_pair_t  io_smeta_ff;
   iox_pair_t  io_s_ff;
   logic [1:0] rd_meta_ff;
   logic [1:0] rd_s_ff;
   logic [1:0] rd_d_ff;
   logic       cfg_meta_ff;
   logic       cfg_s_ff;
   logic       cfg_d_ff;
   iox_pair_t  cfg_sys_ff;
   iox_pair_t  snap_ff;
   logic       init_ff;
   logic       int_oe_n_ff;
   logic [1:0] rd_evt;
   logic       alert0;
   logic       alert1;

   // Pins and toggles through two stages, third stage only for edges
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         io_smeta_ff <= {PIN_RST, PIN_RST};
         io_s_ff     <= {PIN_RST, PIN_RST};
         rd_meta_ff  <= 2'h0;
         rd_s_ff     <= 2'h0;
         rd_d_ff     <= 2'h0;
         cfg_meta_ff <= 1'h0;
         cfg_s_ff    <= 1'h0;
         cfg_d_ff    <= 1'h0;
      end else if (clk_en) begin
         io_smeta_ff <= io_in;
         io_s_ff     <= io_smeta_ff;
         rd_meta_ff  <= rd_tgl_ff;
         rd_s_ff     <= rd_meta_ff;
         rd_d_ff     <= rd_s_ff;
         cfg_meta_ff <= cfg_tgl_ff;
         cfg_s_ff    <= cfg_meta_ff;
         cfg_d_ff    <= cfg_s_ff;
      end
   end

   assign rd_evt = clk_en ? (rd_s_ff ^ rd_d_ff) : 2'h0;

   // Held words are safe to sample: they only change a whole byte later
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_sys_ff <= {CFG_RST, CFG_RST};
         snap_ff    <= {PIN_RST, PIN_RST};
         init_ff    <= 1'h0;
      end else if (clk_en) begin
         if (cfg_s_ff ^ cfg_d_ff) begin
            cfg_sys_ff <= cfg_ff;
         end
         if (!init_ff) begin
            snap_ff <= io_s_ff;
            init_ff <= 1'h1;
         end else begin
            if (rd_evt[0]) snap_ff.p0 <= rd_raw_ff.p0;
            if (rd_evt[1]) snap_ff.p1 <= rd_raw_ff.p1;
         end
      end
   end

   // A change after the read was snapped stays visible: no lost event
   assign alert0 = |((io_s_ff.p0 ^ snap_ff.p0) & cfg_sys_ff.p0);
   assign alert1 = |((io_s_ff.p1 ^ snap_ff.p1) & cfg_sys_ff.p1);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         int_oe_n_ff <= 1'h1;
      end else if (clk_en) begin
         int_oe_n_ff <= ~(init_ff & (alert0 | alert1));
      end
   end

   assign int_o    = 1'h0;
   assign int_oe_n = int_oe_n_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_rx_byte_end;
      (state_ff == ST_CMD || state_ff == ST_WDAT) && byte_done && !start_det && !stop_det;
   endsequence
   sequence s_nack;
      state_ff == ST_MACK && scl_rise && line_ff.sda && !start_det && !stop_det;
   endsequence

   property p_rx_ack;
      @(posedge link_clk) disable iff (link_rst_ff)
      s_rx_byte_end |=> state_ff == ST_SACK && !sda_oe_n_ff;
   endproperty
   a_rx_ack: assert property (p_rx_ack) else $error("no ack after received byte");

   property p_nack_release;
      @(posedge link_clk) disable iff (link_rst_ff)
      s_nack |=> state_ff == ST_IDLE && sda_oe_n_ff;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("sda held after nack");

   property p_idle_free;
      @(posedge link_clk) disable iff (link_rst_ff)
      (state_ff == ST_IDLE && $past(state_ff) == ST_IDLE) |-> sda_oe_n_ff;
   endproperty
   a_idle_free: assert property (p_idle_free) else $error("sda driven while idle");

   property p_start;
      @(posedge link_clk) disable iff (link_rst_ff)
      start_det |=> state_ff == ST_ADDR && cnt_ff == CNT_ZERO;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_stop;
      @(posedge link_clk) disable iff (link_rst_ff)
      stop_det |=> state_ff == ST_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");

   property p_sda_steady;
      @(posedge link_clk) disable iff (link_rst_ff)
      $changed(sda_oe_n_ff) |-> $past(scl_fall) || $past(start_det) || $past(stop_det)
                                || state_ff == ST_IDLE;
   endproperty
   a_sda_steady: assert property (p_sda_steady) else $error("sda moved with scl high");

   property p_bit_count;
      @(posedge link_clk) disable iff (link_rst_ff)
      cnt_ff <= BITS_PER_BYTE;
   endproperty
   a_bit_count: assert property (p_bit_count) else $error("bit count overrun");

   property p_ack_release;
      @(posedge link_clk) disable iff (link_rst_ff)
      (state_ff == ST_TX && byte_done && !start_det && !stop_det) |=>
         (state_ff == ST_MACK && sda_oe_n_ff) [*2];
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("sda held in ack slot");

   property p_alternate;
      @(posedge link_clk) disable iff (link_rst_ff)
      tx_load |=> ptr_ff[0] != $past(ptr_ff[0]) && ptr_ff[2:1] == $past(ptr_ff[2:1]);
   endproperty
   a_alternate: assert property (p_alternate) else $error("read did not alternate");

   property p_alert_set;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && init_ff && (alert0 || alert1)) |=> !int_oe_n_ff;
   endproperty
   a_alert_set: assert property (p_alert_set) else $error("alert not raised");

   property p_alert_clear;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && !alert0 && !alert1) |=> int_oe_n_ff;
   endproperty
   a_alert_clear: assert property (p_alert_clear) else $error("alert not released");

   property p_port_iso;
      @(posedge clock) disable iff (sys_rst)
      (init_ff && rd_evt[0] && !rd_evt[1]) |=> snap_ff.p1 == $past(snap_ff.p1);
   endproperty
   a_port_iso: assert property (p_port_iso) else $error("port 0 read touched port 1");

endmodule
`default_nettype wire

// ==== rtl/iox_pkg.sv ====
package iox_pkg;

   // Fixed upper four bits of the device address, low three come from straps
   localparam logic [3:0] ADDR_BASE     = 4'h4;
   // Register pairs, selected by command bits 2:1; bit 0 picks the port
   localparam logic [1:0] PAIR_IN       = 2'h0;
   localparam logic [1:0] PAIR_OUT      = 2'h1;
   localparam logic [1:0] PAIR_POL      = 2'h2;
   localparam logic [1:0] PAIR_CFG      = 2'h3;
   // Reset values
   localparam logic [7:0] OUT_RST       = 8'hff;
   localparam logic [7:0] POL_RST       = 8'h00;
   localparam logic [7:0] CFG_RST       = 8'hff;
   localparam logic [7:0] PIN_RST       = 8'hff;
   localparam logic [2:0] PTR_RST       = 3'h0;
   // Serial framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] CNT_ZERO      = 4'h0;
   localparam logic [3:0] CNT_ONE       = 4'h1;

   // Two 8-bit ports of one register pair
   typedef struct packed {
      logic [7:0] p1;
      logic [7:0] p0;
   } iox_pair_t;

   // Sampled bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } iox_line_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD  = 3'b010,
      ST_WDAT = 3'b011,
      ST_SACK = 3'b100,
      ST_TX   = 3'b101,
      ST_MACK = 3'b110
   } iox_state_t;

endpackage

// ==== testbench/iox_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module iox_master_model (
   // Bus lines driven by the master
   output logic     scl,
   output logic     sda_m,
   // Resolved data wire
   input  wire logic sda_w
);
   // Quarter bit time, far slower than the device's oversampling
   localparam time Q = 200ns;

   ////////////////////////////////////////////////////////////////////////
   // Idle bus: both lines released high
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   // Start, or repeated start when entered with the clock low
   task automatic start();
      sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q sda_m = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask

   // Stop from a low clock
   task automatic stop();
      sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #Q;
   endtask

   // One clock pulse; data settles while the clock is low
   task automatic bit_tx(input logic b, output logic r);
      sda_m = b;
      #Q scl = 1'b1;
      #Q r = sda_w;
      #Q scl = 1'b0;
      #Q;
   endtask

   // Byte out MSB first, then a released ninth pulse
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_tx(d[i], r);
      end
      bit_tx(1'b1, r);
      ack = ~r;
   endtask

   // Byte in; the last byte of a read is not acknowledged
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_tx(1'b1, d[i]);
      end
      bit_tx(last, r);
   endtask
endmodule
`default_nettype wire

// ==== testbench/iox_top_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module iox_top_tb_top;
   import iox_pkg::*;
   logic       clock, sys_rst, clk_en, link_clk, scl, sda_m;
   logic       sda_o, sda_oe_n, int_o, int_oe_n, ack;
   logic [2:0] addr_pins;
   logic [7:0] rb0, rb1;
   iox_pair_t  io_in, io_out, io_oe_n;
   wire        sda_w;
   int         failures = 0;
   int         checked = 0;
   int         cycles = 0;

   ////////////////////////////////////////////////////////////////////////
   // Open-drain data wire with pull-up
   assign sda_w = sda_m & (sda_oe_n | sda_o);

   iox_top u_iox_top (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
      .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .addr_pins(addr_pins), .io_in(io_in),
      .io_out(io_out), .io_oe_n(io_oe_n), .int_o(int_o), .int_oe_n(int_oe_n));

   iox_master_model u_iox_master_model (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));

   // Clocks, link clock free running and unrelated in phase
   initial clock = 1'b0;
   initial link_clk = 1'b0;
   always #25 clock = ~clock;
   always #7.5 link_clk = ~link_clk;

   // Hang guard, well above the expected run of some seven thousand one hundred cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Alert level awaited a bounded time, then judged; sampled after the edge settles
   task automatic wait_int(input logic lvl);
      for (int i = 0; i < 20 && int_oe_n !== lvl; i++) begin
         @(posedge clock);
         #1;
      end
      chk({15'h0, int_oe_n}, {15'h0, lvl});
   endtask

   task automatic set_pins(input logic [15:0] v);
      @(posedge clock);
      #1 io_in = v;
   endtask

   // Address, command and two data bytes, each acknowledged
   task automatic wr2(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
      u_iox_master_model.start();
      u_iox_master_model.wr_byte({ADDR_BASE, addr_pins, 1'b0}, ack);
      chk({15'h0, ack}, 16'h0001);
      u_iox_master_model.wr_byte(cmd, ack);
      chk({15'h0, ack}, 16'h0001);
      u_iox_master_model.wr_byte(d0, ack);
      chk({15'h0, ack}, 16'h0001);
      u_iox_master_model.wr_byte(d1, ack);
      chk({15'h0, ack}, 16'h0001);
      u_iox_master_model.stop();
   endtask

   // Pointer set, repeated start, one or two bytes read
   task automatic rd(input logic [7:0] cmd, input int n);
      u_iox_master_model.start();
      u_iox_master_model.wr_byte({ADDR_BASE, addr_pins, 1'b0}, ack);
      u_iox_master_model.wr_byte(cmd, ack);
      u_iox_master_model.start();
      u_iox_master_model.wr_byte({ADDR_BASE, addr_pins, 1'b1}, ack);
      chk({15'h0, ack}, 16'h0001);
      u_iox_master_model.rd_byte(n == 1, rb0);
      if (n == 2) begin
         u_iox_master_model.rd_byte(1'b1, rb1);
      end
      chk({15'h0, sda_oe_n}, 16'h0001);
      u_iox_master_model.stop();
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(io_out, 16'hffff);
      chk(io_oe_n, 16'hffff);
      chk({14'h0, sda_oe_n, int_oe_n}, 16'h0003);
      chk({14'h0, sda_o, int_o}, 16'h0000);
   endtask

   task automatic t_write();
      wr2(8'h03, 8'ha5, 8'h5a);
      chk(io_out, 16'ha55a);
      wr2(8'h06, 8'h0f, 8'hff);
      chk(io_oe_n, 16'hff0f);
      // Foreign address must be ignored
      u_iox_master_model.start();
      u_iox_master_model.wr_byte({ADDR_BASE, ~addr_pins, 1'b0}, ack);
      u_iox_master_model.stop();
      chk({15'h0, ack}, 16'h0000);
   endtask

   task automatic t_alert();
      set_pins(16'hff7f);
      repeat (20) @(posedge clock);
      chk({15'h0, int_oe_n}, 16'h0001);
      set_pins(16'hff7e);
      wait_int(1'b0);
      set_pins(16'hff7f);
      wait_int(1'b1);
      set_pins(16'hfe7f);
      wait_int(1'b0);
      rd(8'h00, 1);
      chk({8'h0, rb0}, 16'h007f);
      repeat (20) @(posedge clock);
      chk({15'h0, int_oe_n}, 16'h0000);
      rd(8'h01, 1);
      chk({8'h0, rb0}, 16'h00fe);
      wait_int(1'b1);
   endtask

   task automatic t_read();
      set_pins(16'h3c7f);
      wr2(8'h04, 8'h01, 8'h00);
      rd(8'h00, 2);
      chk({rb0, rb1}, 16'h7e3c);
      rd(8'h01, 2);
      chk({rb0, rb1}, 16'h3c7e);
      wait_int(1'b1);
      // Output, configuration and inversion pairs read back, both orders
      rd(8'h02, 2);
      chk({rb0, rb1}, 16'h5aa5);
      rd(8'h07, 2);
      chk({rb0, rb1}, 16'hff0f);
      rd(8'h05, 2);
      chk({rb0, rb1}, 16'h0001);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset, then the scenarios in order
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      addr_pins = 3'h5;
      io_in = 16'hffff;
      repeat (5) @(posedge clock);
      #1 sys_rst = 1'b0;
      repeat (10) @(posedge clock);
      t_reset();
      t_write();
      t_alert();
      t_read();
      wrap_up();
   end
endmodule
`default_nettype wire
